/* shared/lane_stripe_pkg.sv */
// Package: constants for the lane striping and deskew reference source
package lane_stripe_pkg;
	localparam int LANES_DEFAULT = 10;
	localparam int LANES_MIN = 4;
	localparam int LANES_MAX = 20;
	localparam int SAMPLES_PER_ELEM = 4;
	localparam int BITS_PER_ELEM = 5;
	localparam int ELEMS_MIN = 2;
	localparam int ELEMS_MAX = 5;
	localparam int REF_RATIO = 16;
	localparam int SYNC_STAGES = 2;
	localparam logic STATUS_IDLE = 1'h0;
	localparam logic STATUS_ALARM = 1'h1;
	localparam logic PAR_EVEN = 1'h0;
	localparam logic PAR_ODD = 1'h1;
	// Parity of element e in a frame of k elements
	function automatic logic elem_parity(input int k, input int e);
		logic p;
		p = PAR_EVEN;
		unique case (k)
			2: p = (e == 1) ? PAR_ODD : PAR_EVEN;
			3: p = (e == 2) ? PAR_ODD : PAR_EVEN;
			4: p = (e >= 2) ? PAR_ODD : PAR_EVEN;
			default: p = (e == 2 || e >= 4) ? PAR_ODD : PAR_EVEN;
		endcase
		return p;
	endfunction
endpackage

/* logic/bit_sync.sv */
// Two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous level and its synchronised copy
	input wire logic asyncIn,
	output logic syncOut
);
	import lane_stripe_pkg::*;

	typedef struct packed {
		logic meta;
		logic stable;
	} sync_state_t;

	sync_state_t state_ff;
	sync_state_t nxt_state;

	// First stage feeds only the second stage
	always_comb begin
		nxt_state.meta = asyncIn;
		nxt_state.stable = state_ff.meta;
		if (!rst_n) begin
			nxt_state = '0;
		end
	end

	always_ff @(posedge clk) begin
		state_ff <= nxt_state;
	end

	assign syncOut = state_ff.stable;
endmodule
`default_nettype wire

/* logic/lane_stripe_deskew_source.sv */
// Round-robin lane striper with deskew reference frame generator and status line
// ----------------------------------------
// Overview of operation
// - Receive reference clock is lane rate over sixteen; here serial bit-enable rate over sixteen
// - Serdes/FEC build drives the receive reference clock
// - Status line: zero idle, one alarm
// - Alarm whenever data not from optical input
// - Source always drives the status line
// - Status is asynchronous; sink must synchronise it
// - Stream striped round-robin, first bit highest lane
// - Optional five-sample inversion in odd elements
// - Deskew frame holds two to five elements
// - Parity order per frame size, even element first
// - Deskew samples lanes from highest down to zero
// - Extra slots resample from highest lane downward
// - Deskew samples taken after inversion
// - Lanes locked to reference at rate over sixteen
// - Parity bit follows every four samples
// - Frames repeat back to back without gaps
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module lane_stripe_deskew_source #(
	parameter int LANES = lane_stripe_pkg::LANES_DEFAULT,
	parameter bit INVERT_EN = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Serial stream in, one bit per bit enable
	input wire logic serialIn,
	input wire logic bitEnable,
	// Receive-path health from the optical front end, asynchronous
	input wire logic opticalValid,
	// Striped lanes and deskew lane out
	output logic [LANES-1:0] laneBus,
	output logic deskewLane,
	output logic wordStrobe,
	// Reference clock and status line
	output logic receiveReferenceClock,
	output logic receiveStatusLine
);
	import lane_stripe_pkg::*;

	// ----------------------------------------
	// Derived sizes
	// ----------------------------------------
	localparam int ELEMS_RAW = (LANES + SAMPLES_PER_ELEM - 1) / SAMPLES_PER_ELEM;
	localparam int ELEMS = (ELEMS_RAW < ELEMS_MIN) ? ELEMS_MIN : ELEMS_RAW;
	localparam int LW = $clog2(LANES);
	localparam int EW = $clog2(ELEMS_MAX);
	localparam int DIVW = $clog2(REF_RATIO / 2);
	localparam logic [LW-1:0] LANE_TOP = LW'(LANES - 1);
	localparam logic [EW-1:0] ELEM_LAST = EW'(ELEMS - 1);
	localparam logic [2:0] POS_PAR = 3'(SAMPLES_PER_ELEM);
	localparam logic [DIVW-1:0] DIV_LAST = DIVW'(REF_RATIO / 2 - 1);

	// Refuse sizes that the frame logic cannot serve
	if (LANES < LANES_MIN || LANES > LANES_MAX) begin : g_bad_lanes
		$error("lane count out of range");
	end
	if (ELEMS > ELEMS_MAX) begin : g_bad_elems
		$error("element count out of range");
	end

	typedef enum logic [0:0] {
		ST_SAMPLE = 1'b0,
		ST_PARITY = 1'b1
	} dsk_state_t;

	typedef struct packed {
		logic [LANES-1:0] shift;
		logic [LANES-1:0] lanes;
		logic [LW-1:0] fillIdx;
		logic strobe;
		logic [LW-1:0] sampIdx;
		logic [2:0] pos;
		logic [EW-1:0] elem;
		logic [2:0] ones;
		dsk_state_t st;
		logic dsk;
		logic [DIVW-1:0] div;
		logic refClk;
		logic status;
	} src_state_t;

	src_state_t state_ff;
	src_state_t nxt_state;
	logic validSync;
	logic elemOdd;
	logic sampleBit;

	// ----------------------------------------
	// Synchroniser for the optical health level
	// ----------------------------------------
	bit_sync u_valid_sync (
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(opticalValid),
		.syncOut(validSync)
	);

	// Parity type of the element now on the deskew lane
	always_comb begin
		elemOdd = PAR_EVEN;
		for (int e = 0; e < ELEMS_MAX; e++) begin
			if (EW'(e) == state_ff.elem) begin
				elemOdd = elem_parity(ELEMS, e);
			end
		end
	end

	// Sample the lane as transmitted, after any inversion
	assign sampleBit = state_ff.lanes[state_ff.sampIdx];

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_state.strobe = 1'b0;
		// Reference divider: one toggle every eight bit times gives rate/16
		if (bitEnable) begin
			if (state_ff.div == DIV_LAST) begin
				nxt_state.div = '0;
				nxt_state.refClk = ~state_ff.refClk;
			end else begin
				nxt_state.div = state_ff.div + 1'b1;
			end
		end
		// Round-robin fill: first bit to highest lane, last to lane zero
		if (bitEnable) begin
			nxt_state.shift[state_ff.fillIdx] = serialIn;
			if (state_ff.fillIdx == '0) begin
				nxt_state.fillIdx = LANE_TOP;
				nxt_state.strobe = 1'b1;
				for (int i = 0; i < LANES; i++) begin
					nxt_state.lanes[i] = (i == 0) ? serialIn : state_ff.shift[i];
				end
				// Invert all lanes for the five samples of an odd element
				if (INVERT_EN && elemOdd == PAR_ODD) begin
					nxt_state.lanes = ~nxt_state.lanes;
				end
			end else begin
				nxt_state.fillIdx = state_ff.fillIdx - 1'b1;
			end
		end
		// Deskew lane: four samples then a parity bit per element, one bit per word
		if (state_ff.strobe) begin
			unique case (state_ff.st)
				ST_SAMPLE: begin
					nxt_state.dsk = sampleBit;
					nxt_state.ones = state_ff.ones + 3'(sampleBit);
					// Wrap to the highest lane, covering leftover slots
					nxt_state.sampIdx = (state_ff.sampIdx == '0) ? LANE_TOP : state_ff.sampIdx - 1'b1;
					nxt_state.pos = state_ff.pos + 1'b1;
					if (state_ff.pos == POS_PAR - 3'h1) begin
						nxt_state.st = ST_PARITY;
					end
				end
				ST_PARITY: begin
					// Parity bit makes five-bit ones count even or odd
					nxt_state.dsk = state_ff.ones[0] ^ elemOdd;
					nxt_state.ones = '0;
					nxt_state.pos = '0;
					nxt_state.st = ST_SAMPLE;
					// Restart frame at once after last element
					if (state_ff.elem == ELEM_LAST) begin
						nxt_state.elem = '0;
						nxt_state.sampIdx = LANE_TOP;
					end else begin
						nxt_state.elem = state_ff.elem + 1'b1;
					end
				end
			endcase
		end
		// Alarm whenever output data is not from the optical signal
		nxt_state.status = validSync ? STATUS_IDLE : STATUS_ALARM;
		if (!rst_n) begin
			nxt_state = '0;
			nxt_state.fillIdx = LANE_TOP;
			nxt_state.sampIdx = LANE_TOP;
			nxt_state.st = ST_SAMPLE;
			nxt_state.status = STATUS_ALARM;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		state_ff <= nxt_state;
	end

	// ----------------------------------------
	// Outputs straight from the state register
	// ----------------------------------------
	assign laneBus = state_ff.lanes;
	assign deskewLane = state_ff.dsk;
	assign wordStrobe = state_ff.strobe;
	assign receiveReferenceClock = state_ff.refClk;
	assign receiveStatusLine = state_ff.status;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_alarm_follows;
		@(posedge clk) disable iff (!rst_n)
		$fell(validSync) |=> receiveStatusLine == STATUS_ALARM;
	endproperty
	a_alarm_follows: assert property (p_alarm_follows) else $error("alarm not raised");

	property p_idle_follows;
		@(posedge clk) disable iff (!rst_n)
		validSync |=> receiveStatusLine == STATUS_IDLE;
	endproperty
	a_idle_follows: assert property (p_idle_follows) else $error("status not idle");

	property p_lane_zero_last;
		@(posedge clk) disable iff (!rst_n)
		(bitEnable && state_ff.fillIdx == '0 && !(INVERT_EN && elemOdd)) |=> laneBus[0] == $past(serialIn);
	endproperty
	a_lane_zero_last: assert property (p_lane_zero_last) else $error("last bit not on lane zero");

	property p_parity_after_four;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.strobe && state_ff.st == ST_SAMPLE && state_ff.pos == 3'h3) |=> state_ff.st == ST_PARITY;
	endproperty
	a_parity_after_four: assert property (p_parity_after_four) else $error("parity slot misplaced");

	property p_parity_value;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.strobe && state_ff.st == ST_PARITY) |=> (^{$past(state_ff.ones[0]), deskewLane}) == $past(elemOdd);
	endproperty
	a_parity_value: assert property (p_parity_value) else $error("element parity wrong");

	property p_frame_wrap;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.strobe && state_ff.st == ST_PARITY && state_ff.elem == ELEM_LAST) |=>
			state_ff.elem == '0 && state_ff.sampIdx == LANE_TOP;
	endproperty
	a_frame_wrap: assert property (p_frame_wrap) else $error("frame did not restart");

	property p_elem_bound;
		@(posedge clk) disable iff (!rst_n)
		state_ff.elem <= ELEM_LAST && ELEMS >= ELEMS_MIN;
	endproperty
	a_elem_bound: assert property (p_elem_bound) else $error("element index out of frame");

	property p_first_even;
		@(posedge clk) disable iff (!rst_n)
		state_ff.elem == '0 |-> elemOdd == PAR_EVEN;
	endproperty
	a_first_even: assert property (p_first_even) else $error("frame start not even");

	property p_sample_wrap;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.strobe && state_ff.st == ST_SAMPLE && state_ff.sampIdx == '0) |=> state_ff.sampIdx == LANE_TOP;
	endproperty
	a_sample_wrap: assert property (p_sample_wrap) else $error("sample index did not wrap");

	property p_ref_toggle;
		@(posedge clk) disable iff (!rst_n)
		(bitEnable && state_ff.div == DIV_LAST) |=> receiveReferenceClock != $past(receiveReferenceClock);
	endproperty
	a_ref_toggle: assert property (p_ref_toggle) else $error("reference clock did not toggle");

	// Odd element words leave inverted when the option is on
	property p_invert_odd;
		@(posedge clk) disable iff (!rst_n)
		(bitEnable && state_ff.fillIdx == '0 && INVERT_EN && elemOdd == PAR_ODD) |=> laneBus[0] == !$past(serialIn);
	endproperty
	a_invert_odd: assert property (p_invert_odd) else $error("odd element word not inverted");

	// Deskew sample equals the lane bit as it left, after inversion
	property p_sample_after_invert;
		@(posedge clk) disable iff (!rst_n)
		(state_ff.strobe && state_ff.st == ST_SAMPLE) |=> deskewLane == $past(laneBus[state_ff.sampIdx]);
	endproperty
	a_sample_after_invert: assert property (p_sample_after_invert) else $error("deskew sample mismatch");

	// Word strobe lasts a single cycle
	property p_strobe_single;
		@(posedge clk) disable iff (!rst_n)
		wordStrobe |=> !wordStrobe;
	endproperty
	a_strobe_single: assert property (p_strobe_single) else $error("word strobe too long");

	// Reference clock moves only with bit times, so it stays locked to the lanes
	property p_ref_still;
		@(posedge clk) disable iff (!rst_n)
		!bitEnable |=> $stable(receiveReferenceClock);
	endproperty
	a_ref_still: assert property (p_ref_still) else $error("reference moved without a bit");

	// Deskew lane changes only once per word
	property p_deskew_hold;
		@(posedge clk) disable iff (!rst_n)
		!state_ff.strobe |=> $stable(deskewLane);
	endproperty
	a_deskew_hold: assert property (p_deskew_hold) else $error("deskew bit changed between words");
endmodule
`default_nettype wire

/* verif/lane_sink_model.sv */
// Receive sink model: synchronises the status line and counts words
`timescale 1ns/1ps
`default_nettype none
module lane_sink_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Receive side of the source
	input wire logic wordStrobe,
	input wire logic receiveStatusLine,
	// Synchronised alarm and received word count
	output logic alarmSync,
	output logic [15:0] wordCount
);
	logic meta_ff;
	// Two flops before use, since the status level is asynchronous
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_ff <= 1'h1;
			alarmSync <= 1'h1;
			wordCount <= 16'h0;
		end else begin
			meta_ff <= receiveStatusLine;
			alarmSync <= meta_ff;
			wordCount <= wordCount + {15'h0, wordStrobe};
		end
	end
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the lane striper and deskew source
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lane_stripe_pkg::*;
	localparam int LANES = 10;
	localparam int ELEMS = (LANES + 3) / 4 < 2 ? 2 : (LANES + 3) / 4;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic serialIn = 1'h0;
	logic bitEnable = 1'h0;
	logic opticalValid = 1'h1;
	logic linkClk = 1'h0;
	logic linkPrev = 1'h0;
	logic linkEdge;
	logic [LANES-1:0] laneBus;
	logic deskewLane, wordStrobe, receiveReferenceClock, receiveStatusLine, alarmSync;
	logic [15:0] wordCount;
	logic [31:0] seed = 32'h6089;
	logic [LANES-1:0] buildWord;
	logic [LANES-1:0] expQ[$];
	logic [LANES-1:0] w;
	logic refPrev, deskPend, deskExp, acc;
	logic [LANES-1:0] laneBusInv, wInv;
	logic deskewLaneInv, deskExpInv, accInv;
	int fails = 0;
	int n_checks = 0;
	int cycles = 0;
	int fillIdx = LANES - 1;
	int words = 0;
	int wIdx, beCnt, slot, e;
	// ----------------------------------------
	// Clocks, devices and sink
	// ----------------------------------------
	always #12.5 clk = ~clk; // System clock; linkClk is a second, independent source pacing bit enables
	initial #7 forever #100 linkClk = ~linkClk;
	lane_stripe_deskew_source #(.LANES(LANES), .INVERT_EN(1'b0)) dut (.clk(clk), .rst_n(rst_n),
		.serialIn(serialIn), .bitEnable(bitEnable), .opticalValid(opticalValid), .laneBus(laneBus),
		.deskewLane(deskewLane), .wordStrobe(wordStrobe), .receiveReferenceClock(receiveReferenceClock),
		.receiveStatusLine(receiveStatusLine));
	lane_sink_model sink (.clk(clk), .rst_n(rst_n), .wordStrobe(wordStrobe),
		.receiveStatusLine(receiveStatusLine), .alarmSync(alarmSync), .wordCount(wordCount));
	// Second device with lane inversion on, fed the same stream
	lane_stripe_deskew_source #(.LANES(LANES), .INVERT_EN(1'b1)) dut_inv (.clk(clk), .rst_n(rst_n),
		.serialIn(serialIn), .bitEnable(bitEnable), .opticalValid(opticalValid), .laneBus(laneBusInv),
		.deskewLane(deskewLaneInv), .wordStrobe(), .receiveReferenceClock(), .receiveStatusLine());
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Odd elements per frame size
	function automatic logic oddOf(input int k, input int x);
		return (k == 2) ? (x == 1) : (k == 3) ? (x == 2) : (k == 4) ? (x >= 2) : (x == 2 || x == 4);
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task close_out;
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One cycle of stimulus; notes each finished word, first bit in the top lane
	task automatic step(input logic en);
		logic b;
		seed = lfsr(seed);
		b = seed[0];
		serialIn <= b;
		bitEnable <= en;
		if (en) begin
			buildWord[fillIdx] = b;
			if (fillIdx == 0) begin
				expQ.push_back(buildWord);
				words++;
				fillIdx = LANES - 1;
			end else
				fillIdx--;
		end
		@(posedge clk);
	endtask
	// ----------------------------------------
	// Output watcher
	// ----------------------------------------
	always @(posedge clk) begin
		if (!rst_n) begin
			wIdx = 0;
			beCnt = 0;
			refPrev = 1'h0;
			deskPend = 1'h0;
			acc = 1'h0;
			accInv = 1'h0;
		end else begin
			if (deskPend) chk("deskewLane", {31'h0, deskExp}, {31'h0, deskewLane});
			if (deskPend) chk("deskewLaneInv", {31'h0, deskExpInv}, {31'h0, deskewLaneInv});
			deskPend = 1'h0;
			if (receiveReferenceClock !== refPrev) begin
				chk("refClkEnables", 8, beCnt);
				beCnt = 0;
				refPrev = receiveReferenceClock;
			end
			if (bitEnable)
				beCnt++;
			if (wordStrobe === 1'h1) begin
				w = (expQ.size() > 0) ? expQ.pop_front() : '1;
				chk("laneBus", 32'(w), 32'(laneBus));
				slot = wIdx % (5 * ELEMS);
				e = slot / 5;
				wInv = oddOf(ELEMS, e) ? ~w : w;
				chk("laneBusInv", 32'(wInv), 32'(laneBusInv));
				if (slot % 5 < 4) begin
					deskExp = w[LANES - 1 - ((e * 4 + slot % 5) % LANES)];
					acc = acc ^ deskExp;
					deskExpInv = deskExp ^ oddOf(ELEMS, e);
					accInv = accInv ^ deskExpInv;
				end else begin
					deskExp = acc ^ oddOf(ELEMS, e);
					acc = 1'h0;
					deskExpInv = accInv ^ oddOf(ELEMS, e);
					accInv = 1'h0;
				end
				deskPend = 1'h1;
				wIdx++;
			end
		end
	end
	// Cuts a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			fails++;
			close_out;
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		chk("statusInReset", 32'(STATUS_ALARM), 32'(receiveStatusLine));
		rst_n <= 1'h1;
		@(posedge clk);
		repeat (LANES * 60) step(1'h1);
		repeat (LANES * 60) step(seed[5] | seed[9]);
		repeat (LANES * 80) begin
			linkEdge = linkClk & ~linkPrev;
			linkPrev = linkClk;
			step(linkEdge);
		end
		repeat (4) step(1'h0);
		opticalValid <= 1'h0;
		repeat (5) step(1'h0);
		chk("statusAlarm", 32'(STATUS_ALARM), 32'(receiveStatusLine));
		repeat (3) step(1'h0);
		chk("sinkAlarm", 32'h1, 32'(alarmSync));
		opticalValid <= 1'h1;
		repeat (5) step(1'h0);
		chk("statusIdle", 32'(STATUS_IDLE), 32'(receiveStatusLine));
		chk("wordsLeft", 0, expQ.size());
		chk("sinkWords", 32'(words), 32'(wordCount));
		close_out;
	end
endmodule
`default_nettype wire
